// >>> design/power_mode_clock_selector.sv
`timescale 1ns/10ps
`include "power_clock_defines.svh"

module power_mode_clock_selector #(
	parameter int unsigned PLL_LOCK_CYCLES =
		`PLL_LOCK_NS / `CORE_CLK_PERIOD_NS
) (
	input wire logic I_CORE_CLK,
	input wire logic I_RST,
	input wire logic [7:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic I_SLEEP_EXEC,
	input wire logic I_WAKE,
	input wire logic I_TWO_SPEED,
	input wire logic I_PRI_IS_CRYSTAL,
	input wire logic I_PLL_EN,
	input wire logic I_PRI_OSC_TICK,
	input wire logic I_SEC_OSC_READY,
	input wire logic I_TIMER_SEC_EN,
	input wire logic I_WDT_EN,
	input wire logic I_FAIL_MON_EN,
	output logic [7:0] O_RDATA,
	output logic [1:0] O_SYS_SRC,
	output logic [1:0] O_INT_OSC_SEL,
	output logic O_CPU_CLK_EN,
	output logic O_PERIPH_CLK_EN,
	output logic O_PRI_OSC_EN,
	output logic O_SEC_OSC_EN,
	output logic O_HF_OSC_EN,
	output logic O_LF_OSC_EN
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic power_clock_pkg::src_t css_to_src(
		input logic [1:0] css
	);
		if (css[1])
			return power_clock_pkg::SRC_INT;
		else if (css == `CSS_SECONDARY)
			return power_clock_pkg::SRC_SEC;
		else
			return power_clock_pkg::SRC_PRI;
	endfunction

	function automatic logic ready_of(
		input power_clock_pkg::src_t s,
		input logic pri_ok,
		input logic sec_ok
	);
		case (s)
			power_clock_pkg::SRC_PRI: return pri_ok;
			power_clock_pkg::SRC_SEC: return sec_ok;
			default: return 1'b1;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic idle_on_sleep_bit;
	logic [2:0] internal_freq_select;
	logic [1:0] clock_source_select;
	logic mid_freq_select;
	logic secondary_osc_force_on;
	logic low_source_select;
	logic primary_running_flag;
	logic secondary_running_flag;
	logic high_freq_stable_flag;
	logic mid_freq_stable_flag;
	logic low_freq_stable_flag;
	logic int_flag_mask;
	logic [10:0] ost_cnt;
	logic [31:0] pll_cnt;
	logic [31:0] settle_cnt;
	logic [1:0] gap_cnt;
	power_clock_pkg::mode_t mode;
	power_clock_pkg::src_t cur_src;
	power_clock_pkg::src_t new_src;
	power_clock_pkg::sw_t sw_state;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire sleeping = (mode == power_clock_pkg::MODE_SLEEP);
	wire pcc_wr = I_WR && (I_ADDR == `PCC_ADDR);
	wire pcs_wr = I_WR && (I_ADDR == `PCS_ADDR);
	wire tune_wr = I_WR && (I_ADDR == `TUNE_ADDR);
	power_clock_pkg::src_t tgt_src;
	assign tgt_src = css_to_src(clock_source_select);

	// Secondary may only be used once something keeps it alive.
	wire sec_ok = (secondary_osc_force_on || I_TIMER_SEC_EN)
		&& I_SEC_OSC_READY;

	wire ost_ok = !I_PRI_IS_CRYSTAL || (ost_cnt == `OST_PERIODS);
	wire pll_ok = !I_PLL_EN || (pll_cnt == PLL_LOCK_CYCLES);
	wire pri_ready = O_PRI_OSC_EN && ost_ok && pll_ok;

	wire int_cond = (internal_freq_select != 3'h0)
		|| low_source_select || mid_freq_select;
	wire int_on = int_cond && !sleeping;
	wire int_settled = int_on
		&& (settle_cnt == 32'(`IOSC_SETTLE_CYCLES));

	power_clock_pkg::iosc_t choice;
	wire ifs_low = (internal_freq_select <= 3'h2);
	wire ifs_zero = (internal_freq_select == 3'h0);
	assign choice = (ifs_zero && !low_source_select) ?
		power_clock_pkg::IOSC_LF :
		(ifs_low && mid_freq_select) ? power_clock_pkg::IOSC_MF :
		power_clock_pkg::IOSC_HF;

	wire cur_ok = ready_of(cur_src, pri_ready, sec_ok);
	wire tgt_ok = ready_of(tgt_src, pri_ready, sec_ok);
	wire in_gap = (sw_state == power_clock_pkg::SW_GAP);
	wire gap_last = in_gap && (gap_cnt == 2'(`CHANGEOVER_CYCLES - 1));

	// ----------------------------------------------------------------
	// Next values of the outputs
	// ----------------------------------------------------------------
	// Both enables drop for the changeover so no shortened pulse leaks.
	wire next_periph = !sleeping && !in_gap && cur_ok;
	wire next_cpu = next_periph
		&& (mode == power_clock_pkg::MODE_RUN);
	wire next_pri_en = !sleeping
		&& (cur_src == power_clock_pkg::SRC_PRI
		|| tgt_src == power_clock_pkg::SRC_PRI);
	wire next_sec_en = secondary_osc_force_on || I_TIMER_SEC_EN
		|| (!sleeping && cur_src == power_clock_pkg::SRC_SEC);
	wire next_lf_en = I_WDT_EN || I_FAIL_MON_EN || (!sleeping
		&& cur_src == power_clock_pkg::SRC_INT
		&& choice == power_clock_pkg::IOSC_LF);

	// ----------------------------------------------------------------
	// Flag values
	// ----------------------------------------------------------------
	wire next_primary_run_mode = !sleeping && !in_gap && pri_ready
		&& cur_src == power_clock_pkg::SRC_PRI;
	wire next_secondary_run_mode = !sleeping && !in_gap
		&& cur_src == power_clock_pkg::SRC_SEC;
	wire int_flag_ok = int_settled && !int_flag_mask;
	wire next_hf_st = int_flag_ok
		&& choice == power_clock_pkg::IOSC_HF;
	wire next_mf_st = int_flag_ok
		&& choice == power_clock_pkg::IOSC_MF;
	wire next_lf_st = !sleeping && next_lf_en;

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	wire [7:0] pcc_val = {idle_on_sleep_bit, internal_freq_select,
		primary_running_flag, high_freq_stable_flag,
		clock_source_select};
	wire [7:0] pcs_val = {1'b0, secondary_running_flag, 1'b0,
		mid_freq_select, secondary_osc_force_on, 1'b0,
		mid_freq_stable_flag, low_freq_stable_flag};
	wire [7:0] tune_val = {low_source_select, 7'h00};
	wire [7:0] next_rdata = !I_RD ? 8'h00 :
		(I_ADDR == `PCC_ADDR) ? pcc_val :
		(I_ADDR == `PCS_ADDR) ? pcs_val :
		(I_ADDR == `TUNE_ADDR) ? tune_val : 8'h00;

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			idle_on_sleep_bit <= 1'b0;
			internal_freq_select <= `IFS_RESET;
			clock_source_select <= `CSS_RESET;
		end else if (pcc_wr) begin
			idle_on_sleep_bit <= I_WDATA[`PCC_IDLE_BIT];
			internal_freq_select <=
				I_WDATA[`PCC_IFS_HI:`PCC_IFS_LO];
			clock_source_select <=
				I_WDATA[`PCC_CSS_HI:`PCC_CSS_LO];
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			mid_freq_select <= 1'b0;
			secondary_osc_force_on <= 1'b0;
			low_source_select <= 1'b0;
		end else begin
			if (pcs_wr) begin
				mid_freq_select <= I_WDATA[`PCS_MID_SEL_BIT];
				secondary_osc_force_on <= I_WDATA[`PCS_FORCE_BIT];
			end
			if (tune_wr)
				low_source_select <= I_WDATA[`TUNE_LOW_SRC_BIT];
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST)
			O_RDATA <= 8'h00;
		else
			O_RDATA <= next_rdata;
	end

	// ----------------------------------------------------------------
	// Power mode
	// ----------------------------------------------------------------
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			mode <= power_clock_pkg::MODE_RUN;
		end else begin
			case (mode)
				power_clock_pkg::MODE_RUN: begin
					if (I_SLEEP_EXEC)
						mode <= idle_on_sleep_bit ?
							power_clock_pkg::MODE_IDLE :
							power_clock_pkg::MODE_SLEEP;
				end
				power_clock_pkg::MODE_IDLE,
				power_clock_pkg::MODE_SLEEP: begin
					if (I_WAKE)
						mode <= power_clock_pkg::MODE_RUN;
				end
				default: mode <= power_clock_pkg::MODE_RUN;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Source switching
	// ----------------------------------------------------------------
	// The old source keeps clocking while the new one starts up.
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			sw_state <= power_clock_pkg::SW_STABLE;
			cur_src <= I_TWO_SPEED ? power_clock_pkg::SRC_INT :
				power_clock_pkg::SRC_PRI;
			new_src <= power_clock_pkg::SRC_PRI;
			gap_cnt <= 2'h0;
		end else begin
			case (sw_state)
				power_clock_pkg::SW_STABLE: begin
					if (!sleeping && tgt_src != cur_src)
						sw_state <= power_clock_pkg::SW_WAIT;
				end
				power_clock_pkg::SW_WAIT: begin
					if (tgt_src == cur_src) begin
						sw_state <= power_clock_pkg::SW_STABLE;
					end else if (tgt_ok) begin
						sw_state <= power_clock_pkg::SW_GAP;
						new_src <= tgt_src;
						gap_cnt <= 2'h0;
					end
				end
				power_clock_pkg::SW_GAP: begin
					gap_cnt <= gap_cnt + 2'h1;
					if (gap_last) begin
						cur_src <= new_src;
						sw_state <= power_clock_pkg::SW_STABLE;
					end
				end
				default: sw_state <= power_clock_pkg::SW_STABLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Oscillator timers
	// ----------------------------------------------------------------
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST || !O_PRI_OSC_EN)
			ost_cnt <= 11'h000;
		else if (I_PRI_OSC_TICK && ost_cnt != `OST_PERIODS)
			ost_cnt <= ost_cnt + 11'h001;
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST || !O_PRI_OSC_EN || !ost_ok)
			pll_cnt <= 32'h0;
		else if (pll_cnt != PLL_LOCK_CYCLES)
			pll_cnt <= pll_cnt + 32'h1;
	end

	// Settling restarts only when the output was really off.
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST || !int_on)
			settle_cnt <= 32'h0;
		else if (settle_cnt != 32'(`IOSC_SETTLE_CYCLES))
			settle_cnt <= settle_cnt + 32'h1;
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST || !int_on)
			int_flag_mask <= 1'b0;
		else if (gap_last && cur_src == power_clock_pkg::SRC_INT
			&& new_src == power_clock_pkg::SRC_PRI)
			int_flag_mask <= 1'b1;
		else if (gap_last && new_src == power_clock_pkg::SRC_INT)
			int_flag_mask <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Registered outputs and flags
	// ----------------------------------------------------------------
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			O_CPU_CLK_EN <= 1'b0;
			O_PERIPH_CLK_EN <= 1'b0;
			O_PRI_OSC_EN <= 1'b0;
			O_SEC_OSC_EN <= 1'b0;
			O_LF_OSC_EN <= 1'b0;
			O_HF_OSC_EN <= 1'b0;
			O_SYS_SRC <= 2'h0;
			O_INT_OSC_SEL <= 2'h0;
		end else begin
			O_CPU_CLK_EN <= next_cpu;
			O_PERIPH_CLK_EN <= next_periph;
			O_PRI_OSC_EN <= next_pri_en;
			O_SEC_OSC_EN <= next_sec_en;
			O_LF_OSC_EN <= next_lf_en;
			O_HF_OSC_EN <= int_on;
			O_SYS_SRC <= cur_src;
			O_INT_OSC_SEL <= choice;
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			primary_running_flag <= 1'b0;
			secondary_running_flag <= 1'b0;
			high_freq_stable_flag <= 1'b0;
			mid_freq_stable_flag <= 1'b0;
			low_freq_stable_flag <= 1'b0;
		end else begin
			primary_running_flag <= next_primary_run_mode;
			secondary_running_flag <= next_secondary_run_mode;
			high_freq_stable_flag <= next_hf_st;
			mid_freq_stable_flag <= next_mf_st;
			low_freq_stable_flag <= next_lf_st;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge I_CORE_CLK);
	endclocking
	default disable iff (I_RST);

	sequence s_sleep_cmd(logic idle);
		mode == power_clock_pkg::MODE_RUN && I_SLEEP_EXEC
			&& idle_on_sleep_bit == idle;
	endsequence

	sequence s_gated;
		!O_CPU_CLK_EN && !O_PERIPH_CLK_EN;
	endsequence

	property p_sleep_stop;
		s_sleep_cmd(1'b0) |=> sleeping ##1 s_gated;
	endproperty
	a_sleep_stop: assert property (p_sleep_stop)
		else $error("sleep did not stop all clocks");

	property p_idle_cpu;
		s_sleep_cmd(1'b1) |=> mode == power_clock_pkg::MODE_IDLE
			##1 !O_CPU_CLK_EN
			&& O_PERIPH_CLK_EN == $past(cur_ok && !in_gap);
	endproperty
	a_idle_cpu: assert property (p_idle_cpu)
		else $error("idle entry gated wrong clocks");

	property p_stay_low_power;
		mode != power_clock_pkg::MODE_RUN && !I_WAKE
			|=> mode == $past(mode);
	endproperty
	a_stay_low_power: assert property (p_stay_low_power)
		else $error("low power left without wake");

	property p_no_entry;
		mode == power_clock_pkg::MODE_RUN && !I_SLEEP_EXEC
			|=> mode == power_clock_pkg::MODE_RUN;
	endproperty
	a_no_entry: assert property (p_no_entry)
		else $error("low power entered without sleep");

	property p_sleep_flags;
		sleeping ##1 sleeping |=> !primary_running_flag
			&& !secondary_running_flag && !high_freq_stable_flag
			&& !mid_freq_stable_flag && !low_freq_stable_flag;
	endproperty
	a_sleep_flags: assert property (p_sleep_flags)
		else $error("status flag set during sleep");

	property p_gap;
		$rose(in_gap) |-> in_gap [*3] ##1 !in_gap ##1 O_SYS_SRC == new_src;
	endproperty
	a_gap: assert property (p_gap)
		else $error("changeover length wrong");

	property p_no_runt;
		in_gap |=> !O_PERIPH_CLK_EN;
	endproperty
	a_no_runt: assert property (p_no_runt)
		else $error("clock enabled during changeover");

	property p_lf_keep;
		I_WDT_EN || I_FAIL_MON_EN |=> O_LF_OSC_EN;
	endproperty
	a_lf_keep: assert property (p_lf_keep)
		else $error("low oscillator stopped with watchdog on");

	property p_int_off;
		!int_cond [*2] |=> !O_HF_OSC_EN && !high_freq_stable_flag
			&& !mid_freq_stable_flag;
	endproperty
	a_int_off: assert property (p_int_off)
		else $error("internal output active with selects clear");

	property p_pri_shut;
		cur_src != power_clock_pkg::SRC_PRI
			&& tgt_src != power_clock_pkg::SRC_PRI |=> !O_PRI_OSC_EN;
	endproperty
	a_pri_shut: assert property (p_pri_shut)
		else $error("primary left running");

	property p_settle;
		$rose(int_on) |-> (!high_freq_stable_flag
			&& !mid_freq_stable_flag) [*8];
	endproperty
	a_settle: assert property (p_settle)
		else $error("stable flag before settling");

endmodule

// >>> include/power_clock_defines.svh
`ifndef POWER_CLOCK_DEFINES_SVH
`define POWER_CLOCK_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PCC_ADDR 8'h00
`define PCS_ADDR 8'h01
`define TUNE_ADDR 8'h02

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PCC_IDLE_BIT 7
`define PCC_IFS_HI 6
`define PCC_IFS_LO 4
`define PCC_PRIMARY_RUN_MODE_BIT 3
`define PCC_HF_ST_BIT 2
`define PCC_CSS_HI 1
`define PCC_CSS_LO 0
`define PCS_SECONDARY_RUN_MODE_BIT 6
`define PCS_MID_SEL_BIT 4
`define PCS_FORCE_BIT 3
`define PCS_MF_ST_BIT 1
`define PCS_LF_ST_BIT 0
`define TUNE_LOW_SRC_BIT 7

// ----------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------
`define IFS_RESET 3'h3
`define CSS_RESET 2'h0
`define CSS_PRIMARY 2'h0
`define CSS_SECONDARY 2'h1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CORE_CLK_PERIOD_NS 10
`define OST_PERIODS 11'h400
`define PLL_LOCK_NS 2000000
`define IOSC_SETTLE_NS 2000
`define IOSC_SETTLE_CYCLES \
	((`IOSC_SETTLE_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)
`define CHANGEOVER_CYCLES 3

`endif

// >>> include/power_clock_pkg.sv
package power_clock_pkg;
	typedef enum logic [1:0] {MODE_RUN, MODE_IDLE, MODE_SLEEP} mode_t;
	typedef enum logic [1:0] {SRC_PRI, SRC_SEC, SRC_INT} src_t;
	typedef enum logic [1:0] {SW_STABLE, SW_WAIT, SW_GAP} sw_t;
	typedef enum logic [1:0] {IOSC_LF, IOSC_HF, IOSC_MF} iosc_t;
endpackage

// >>> test/osc_source_model.sv
`timescale 1ns/10ps

module osc_source_model #(
	parameter int SEC_START_CYCLES = 50
) (
	input wire logic i_clk,
	input wire logic i_pri_en,
	input wire logic i_sec_en,
	output logic o_pri_tick,
	output logic o_sec_ready
);
	int sec_count;

	// ----------------------------------------------------------------
	// Oscillator behaviour
	// ----------------------------------------------------------------
	// A stopped primary gives no ticks; the selector clears its start-up count when the enable drops.
	initial begin
		o_pri_tick = 1'b0;
		o_sec_ready = 1'b0;
		sec_count = 0;
	end

	always @(posedge i_clk) begin
		o_pri_tick <= i_pri_en;
		if (!i_sec_en) begin
			sec_count <= 0;
			o_sec_ready <= 1'b0;
		end else if (sec_count >= SEC_START_CYCLES) begin
			o_sec_ready <= 1'b1;
		end else begin
			sec_count <= sec_count + 1;
		end
	end
endmodule

// >>> test/power_mode_clock_selector_bench.sv
`timescale 1ns/10ps

module power_mode_clock_selector_bench;
	logic clk, rst, wr, rd, slp, wake, wdt, fmon, tsec;
	logic [7:0] addr, wdata, rdata, d;
	logic [1:0] src, isel;
	logic cpu, per, pri_en, sec_en, hf_en, lf_en, tick, sready;
	logic tsp, xtal, pll;
	int err_count, cmp_count, waited;
	logic [2:0] tab_f [6] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h7};
	logic tab_l [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
	logic tab_m [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
	logic [1:0] tab_e [6] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h2, 2'h1};

	power_mode_clock_selector #(.PLL_LOCK_CYCLES(20)) dut (
		.I_CORE_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata),
		.I_WR(wr), .I_RD(rd), .I_SLEEP_EXEC(slp), .I_WAKE(wake),
		.I_TWO_SPEED(tsp), .I_PRI_IS_CRYSTAL(xtal), .I_PLL_EN(pll),
		.I_PRI_OSC_TICK(tick), .I_SEC_OSC_READY(sready),
		.I_TIMER_SEC_EN(tsec), .I_WDT_EN(wdt), .I_FAIL_MON_EN(fmon),
		.O_RDATA(rdata), .O_SYS_SRC(src), .O_INT_OSC_SEL(isel),
		.O_CPU_CLK_EN(cpu), .O_PERIPH_CLK_EN(per), .O_PRI_OSC_EN(pri_en),
		.O_SEC_OSC_EN(sec_en), .O_HF_OSC_EN(hf_en), .O_LF_OSC_EN(lf_en)
	);

	osc_source_model partner (
		.i_clk(clk), .i_pri_en(pri_en), .i_sec_en(sec_en),
		.o_pri_tick(tick), .o_sec_ready(sready)
	);

	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task automatic tally_and_finish;
		$display("errors %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask

	task automatic pulse(input int which);
		@(posedge clk);
		if (which == 0)
			slp <= 1'b1;
		else
			wake <= 1'b1;
		@(posedge clk);
		slp <= 1'b0;
		wake <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask

	// Polls the source (sel 0) or the CPU clock enable (sel 1).
	task automatic wait_for(input int sel, input logic [1:0] v, input int lim);
		int n = 0;
		#1;
		while (((sel == 0) ? src : {1'b0, cpu}) !== v && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
		waited = n;
		if (n >= lim) begin
			err_count++;
			$display("mismatch at %0t: wait ran out", $time);
			tally_and_finish();
		end
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		slp = 1'b0;
		wake = 1'b0;
		wdt = 1'b0;
		fmon = 1'b0;
		tsec = 1'b0;
		tsp = 1'b0;
		xtal = 1'b1;
		pll = 1'b1;
		addr = 8'h00;
		wdata = 8'h00;
		err_count = 0;
		cmp_count = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		wait_for(1, 2'h1, 1300);
		check(8'(waited >= 1024), 8'h01);
		check({6'h00, src}, 8'h00);
		rd_reg(8'h00, d);
		check(d & 8'hFB, 8'h38);
		rd_reg(8'h03, d);
		check(d, 8'h00);
		// Idle keeps peripherals clocked; the bit alone changes nothing.
		wr_reg(8'h00, 8'hB0);
		repeat (3) @(posedge clk);
		#1;
		check({7'h00, cpu}, 8'h01);
		pulse(0);
		check({6'h00, cpu, per}, 8'h01);
		check({7'h00, pri_en}, 8'h01);
		pulse(1);
		wait_for(1, 2'h1, 10);
		// Full sleep with the watchdog holding the low oscillator up.
		wr_reg(8'h00, 8'h30);
		wdt <= 1'b1;
		fmon <= 1'b1;
		pulse(0);
		check({6'h00, cpu, per}, 8'h00);
		check({6'h00, pri_en, lf_en}, 8'h01);
		rd_reg(8'h00, d);
		check(d & 8'h0C, 8'h00);
		rd_reg(8'h01, d);
		check(d & 8'h43, 8'h00);
		pulse(1);
		wait_for(1, 2'h1, 1300);
		check({6'h00, src}, 8'h00);
		// Internal run; the lower select bit is ignored while the upper one is set.
		wr_reg(8'h00, 8'h72);
		wait_for(0, 2'h2, 10);
		check({7'h00, pri_en}, 8'h00);
		rd_reg(8'h00, d);
		check(d & 8'h0B, 8'h02);
		wr_reg(8'h00, 8'h73);
		repeat (10) @(posedge clk);
		#1;
		check({6'h00, src}, 8'h02);
		wr_reg(8'h00, 8'h02);
		repeat (3) @(posedge clk);
		#1;
		check({5'h00, isel, hf_en}, 8'h00);
		rd_reg(8'h01, d);
		check(d & 8'h02, 8'h00);
		wr_reg(8'h00, 8'h72);
		rd_reg(8'h00, d);
		check(d & 8'h04, 8'h00);
		repeat (210) @(posedge clk);
		rd_reg(8'h00, d);
		check(d & 8'h04, 8'h04);
		wr_reg(8'h00, 8'h62);
		rd_reg(8'h00, d);
		check(d & 8'h04, 8'h04);
		for (int i = 0; i < 6; i++) begin
			wr_reg(8'h02, {tab_l[i], 7'h00});
			wr_reg(8'h01, {3'h0, tab_m[i], 4'h0});
			wr_reg(8'h00, {1'b0, tab_f[i], 4'h2});
			repeat (2) @(posedge clk);
			#1;
			check({6'h00, isel}, {6'h00, tab_e[i]});
		end
		// Back to primary: the internal clock carries on meanwhile.
		wr_reg(8'h00, 8'h70);
		repeat (100) @(posedge clk);
		#1;
		check({6'h00, src}, 8'h02);
		wait_for(0, 2'h0, 1300);
		rd_reg(8'h00, d);
		check(d & 8'h0F, 8'h08);
		// Secondary without a keep-alive must not be entered.
		wr_reg(8'h00, 8'h71);
		repeat (100) @(posedge clk);
		#1;
		check({6'h00, src}, 8'h00);
		wr_reg(8'h01, 8'h08);
		wait_for(0, 2'h1, 300);
		check({7'h00, pri_en}, 8'h00);
		rd_reg(8'h01, d);
		check(d & 8'h40, 8'h40);
		rd_reg(8'h00, d);
		check(d & 8'h08, 8'h00);
		wr_reg(8'h00, 8'h70);
		repeat (100) @(posedge clk);
		#1;
		check({6'h00, src}, 8'h01);
		wait_for(0, 2'h0, 1300);
		check({7'h00, sec_en}, 8'h01);
		rd_reg(8'h01, d);
		check(d & 8'h40, 8'h00);
		rd_reg(8'h00, d);
		check(d & 8'h08, 8'h08);
		// A timer enable alone keeps the secondary alive.
		wr_reg(8'h01, 8'h00);
		tsec <= 1'b1;
		wr_reg(8'h00, 8'h71);
		wait_for(0, 2'h1, 300);
		// Second reset: two-speed start, then a primary that needs no timers.
		tsp <= 1'b1;
		xtal <= 1'b0;
		pll <= 1'b0;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		check({6'h00, src}, 8'h02);
		wait_for(0, 2'h0, 20);
		check(8'(waited < 10), 8'h01);
		tally_and_finish();
	end
endmodule
